/* File: ddrc_core.sv */
/*
 * DDR2 SDRAM die access core: command decoder, four banks, burst engine
 * with double rate data path, byte masks, auto precharge, power states.
 * Assumes the controller keeps bank state correct and drives write data
 * with its strobe qualifiers; the strobe beats arrive as a rise/fall pair
 * per link clock cycle.
 */
//
// Behaviour
// - Commands sampled only at rising link clock
// - Rising ck edge times every command
// - Write data taken on both strobe edges
// - Read data launched on both edges
// - Device drives strobe only during reads
// - Read strobe edges aligned with data
// - Separate strobe pair per data byte
// - Two-beat prefetch word per array access
// - ACTIVE picks bank and row
// - READ/WRITE picks bank and start column
// - Burst walks programmed length and order
// - Burst length four or eight
// - New read/write cuts eight-beat burst
// - Auto precharge closes row after burst
// - Four concurrently operable banks
// - Self refresh and power-down modes
// - Chip select high masks commands
// - Masked byte left unchanged on write
// - Precharge: A10 low one bank, high all
// - Bank inputs select target bank
`timescale 1ns/1ps
`default_nettype none

module ddrc_core
    import ddrc_pkg::*;
#(
    parameter int ROW_W = 13,
    parameter int COL_W = 10,
    parameter int CL = READ_LAT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic [15:0] wdata_rise,
    input wire logic [15:0] wdata_fall,
    input wire logic [1:0] dm_rise,
    input wire logic [1:0] dm_fall,
    input wire logic [1:0] dqs_rise_in,
    input wire logic [1:0] dqs_fall_in,
    output logic [15:0] rdata_rise,
    output logic [15:0] rdata_fall,
    output logic dq_oe,
    output logic [1:0] dqs_oe,
    output logic [3:0] stat_banks_open,
    output logic stat_self_refresh,
    output logic stat_power_down,
    output logic stat_burst_busy
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int AW = 2 + ROW_W + COL_W;
    localparam int DEPTH = 1 << AW;
    localparam logic [3:0] LAT_LOAD = 4'(CL - 1);

    logic [7:0] mem_lo [DEPTH];
    logic [7:0] mem_hi [DEPTH];

    logic rst_s1_reg, rst_s2_reg, ce_s1_reg, ce_s2_reg;
    logic rst_ck, en_ck;
    logic [2:0] cmd;
    logic cmd_vld;
    logic mode_bl8_reg, mode_inter_reg;
    logic [3:0] bank_open_reg;
    logic [ROW_W-1:0] bank_row_reg [NUM_BANKS];
    ddrc_pstate_t pstate_reg;
    logic busy_reg, is_wr_reg, ap_reg;
    logic [3:0] lat_reg;
    logic [1:0] pair_reg;
    logic [1:0] bank_b_reg;
    logic [COL_W-1:0] col_reg;
    logic beat_now, last_pair, start_rd, start_wr;
    logic [2:0] off_a, off_b;
    logic [AW-1:0] adr_a, adr_b;
    logic [6:0] stat_s1_reg, stat_s2_reg;

    // Column offset of beat i within its block
    function automatic logic [2:0] beat_off(
        input logic [2:0] start,
        input logic [2:0] i,
        input logic bl8,
        input logic inter
    );
        logic [2:0] off;
        off = 3'h0;
        if (inter) begin
            off = start ^ i;
        end else begin
            off = {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
        end
        if (!bl8) begin
            off[2] = start[2];
        end
        return off;
    endfunction

    // ------------------------------------------------------------------
    // Reset and clock enable crossing into the link domain
    // ------------------------------------------------------------------
    // Two-flop synchronisers, the first stage read only by the second
    always_ff @(posedge ck) begin
        rst_s1_reg <= srst;
        rst_s2_reg <= rst_s1_reg;
        ce_s1_reg <= ce;
        ce_s2_reg <= ce_s1_reg;
    end

    assign rst_ck = rst_s2_reg;
    assign en_ck = ce_s2_reg;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Chip select high or a low-power state masks the decoder
    assign cmd = {ras_n, cas_n, we_n};
    assign cmd_vld = !cs_n && cke && (pstate_reg == PS_ACTIVE);
    assign start_rd = cmd_vld && (cmd == CMD_READ);
    assign start_wr = cmd_vld && (cmd == CMD_WRITE);

    // Burst beat timing and addresses of the two beats of this cycle
    assign beat_now = busy_reg && (lat_reg == 4'h0);
    assign last_pair = mode_bl8_reg ? (pair_reg == 2'h3) : (pair_reg == 2'h1);
    assign off_a = beat_off(col_reg[2:0], {pair_reg, 1'b0}, mode_bl8_reg,
                            mode_inter_reg);
    assign off_b = beat_off(col_reg[2:0], {pair_reg, 1'b1}, mode_bl8_reg,
                            mode_inter_reg);
    assign adr_a = {bank_b_reg, bank_row_reg[bank_b_reg],
                    col_reg[COL_W-1:3], off_a};
    assign adr_b = {bank_b_reg, bank_row_reg[bank_b_reg],
                    col_reg[COL_W-1:3], off_b};

    // ------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------
    // Burst length and burst type from a load-mode command
    always_ff @(posedge ck) begin
        if (rst_ck) begin
            mode_bl8_reg <= MODE_BL8_RST;
            mode_inter_reg <= MODE_INTER_RST;
        end else if (en_ck && cmd_vld && cmd == CMD_LOAD_MODE &&
                     ba == MODE_REG_SEL) begin
            mode_bl8_reg <= (addr[MODE_BL_LSB +: 3] == MODE_BL8_CODE);
            mode_inter_reg <= addr[MODE_BT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------------
    // Open, close and auto precharge per bank, each bank independent
    always_ff @(posedge ck) begin
        if (rst_ck) begin
            bank_open_reg <= BANKS_OPEN_RST;
        end else if (en_ck) begin
            if (beat_now && last_pair && ap_reg) begin
                bank_open_reg[bank_b_reg] <= 1'b0;
            end
            if (cmd_vld && cmd == CMD_ACTIVE) begin
                bank_open_reg[ba] <= 1'b1;
            end else if (cmd_vld && cmd == CMD_PRECHARGE) begin
                if (addr[AUTO_PRE_BIT]) begin
                    bank_open_reg <= 4'h0;
                end else begin
                    bank_open_reg[ba] <= 1'b0;
                end
            end
        end
    end

    // Row latched per bank on activation
    always_ff @(posedge ck) begin
        if (en_ck && cmd_vld && cmd == CMD_ACTIVE) begin
            bank_row_reg[ba] <= addr[ROW_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    // Refresh with cke low enters self refresh, idle cke low power-down
    always_ff @(posedge ck) begin
        if (rst_ck) begin
            pstate_reg <= PS_ACTIVE;
        end else if (en_ck) begin
            unique case (pstate_reg)
                PS_ACTIVE: begin
                    if (!cke && !cs_n && cmd == CMD_REFRESH &&
                        bank_open_reg == 4'h0) begin
                        pstate_reg <= PS_SREF;
                    end else if (!cke && !busy_reg) begin
                        pstate_reg <= PS_PDOWN;
                    end
                end
                PS_PDOWN, PS_SREF: begin
                    if (cke) begin
                        pstate_reg <= PS_ACTIVE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------------
    // A new read or write restarts the burst, cutting the running one
    always_ff @(posedge ck) begin
        if (rst_ck) begin
            busy_reg <= 1'b0;
            is_wr_reg <= 1'b0;
            ap_reg <= 1'b0;
            lat_reg <= 4'h0;
            pair_reg <= 2'h0;
            bank_b_reg <= 2'h0;
            col_reg <= '0;
        end else if (en_ck) begin
            if (start_rd || start_wr) begin
                busy_reg <= 1'b1;
                is_wr_reg <= start_wr;
                ap_reg <= addr[AUTO_PRE_BIT];
                lat_reg <= LAT_LOAD;
                pair_reg <= 2'h0;
                bank_b_reg <= ba;
                col_reg <= addr[COL_W-1:0];
            end else if (busy_reg && lat_reg != 4'h0) begin
                lat_reg <= 4'(lat_reg - 4'h1);
            end else if (beat_now) begin
                pair_reg <= 2'(pair_reg + 2'h1);
                if (last_pair) begin
                    busy_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Array write path
    // ------------------------------------------------------------------
    // Both strobe beats written per cycle, per byte lane and mask
    always_ff @(posedge ck) begin
        if (en_ck && beat_now && is_wr_reg) begin
            if (dqs_rise_in[0] && !dm_rise[0]) begin
                mem_lo[adr_a] <= wdata_rise[7:0];
            end
            if (dqs_rise_in[1] && !dm_rise[1]) begin
                mem_hi[adr_a] <= wdata_rise[15:8];
            end
            if (dqs_fall_in[0] && !dm_fall[0]) begin
                mem_lo[adr_b] <= wdata_fall[7:0];
            end
            if (dqs_fall_in[1] && !dm_fall[1]) begin
                mem_hi[adr_b] <= wdata_fall[15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read output path
    // ------------------------------------------------------------------
    // Beat pair and strobe enables launched together, edge aligned
    always_ff @(posedge ck) begin
        if (rst_ck) begin
            rdata_rise <= 16'h0000;
            rdata_fall <= 16'h0000;
            dq_oe <= 1'b0;
            dqs_oe <= 2'h0;
        end else if (en_ck) begin
            if (beat_now && !is_wr_reg && !start_rd && !start_wr) begin
                rdata_rise <= {mem_hi[adr_a], mem_lo[adr_a]};
                rdata_fall <= {mem_hi[adr_b], mem_lo[adr_b]};
                dq_oe <= 1'b1;
                dqs_oe <= 2'h3;
            end else begin
                dq_oe <= 1'b0;
                dqs_oe <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status crossing into the system clock domain
    // ------------------------------------------------------------------
    // Independent level bits, two flops each
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_s1_reg <= 7'h00;
            stat_s2_reg <= 7'h00;
        end else if (ce) begin
            stat_s1_reg <= {busy_reg, pstate_reg == PS_PDOWN,
                            pstate_reg == PS_SREF, bank_open_reg};
            stat_s2_reg <= stat_s1_reg;
        end
    end

    assign stat_banks_open = stat_s2_reg[3:0];
    assign stat_self_refresh = stat_s2_reg[4];
    assign stat_power_down = stat_s2_reg[5];
    assign stat_burst_busy = stat_s2_reg[6];

endmodule // ddrc_core

`default_nettype wire

/* File: ddrc_core_asserts.sv */
/* Checker for the DDR2 access core: read latency, burst length, strobes.
   Bound to ddrc_core; sees its ports only, CL at its default of 4. */
`timescale 1ns/1ps
`default_nettype none
module ddrc_core_asserts
    import ddrc_pkg::*;
#(
    parameter int ROW_W = 13,
    parameter int COL_W = 10,
    parameter int CL = READ_LAT_CYC
) (
    input wire logic ck,
    input wire logic srst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic dq_oe,
    input wire logic [1:0] dqs_oe,
    input wire logic [15:0] rdata_rise,
    input wire logic [15:0] rdata_fall
);
    // ----------------------------------------------------------------
    // Decoded commands and burst length copy
    // ----------------------------------------------------------------
    logic [2:0] cmd;
    logic rd, rdwr, fake_rd, bl8_reg;
    assign cmd = {ras_n, cas_n, we_n};
    assign rd = !cs_n && cke && cmd == CMD_READ;
    assign rdwr = rd || (!cs_n && cke && cmd == CMD_WRITE);
    assign fake_rd = cs_n && cmd == CMD_READ;
    // Mode copy from load mode on register 0
    always_ff @(posedge ck) begin
        if (srst) begin
            bl8_reg <= MODE_BL8_RST;
        end else if (!cs_n && cke && cmd == CMD_LOAD_MODE && ba == 2'h0) begin
            bl8_reg <= addr[2:0] == MODE_BL8_CODE;
        end
    end
    default clocking cb @(posedge ck); endclocking
    default disable iff (srst);
    property p_rd_lat; rd ##1 (!rdwr) [*4] |-> ##1 dq_oe; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    property p_rose; $rose(dq_oe) |-> $past(rd, 5); endproperty
    a_rose: assert property (p_rose) else $error("stray read");
    property p_strb; dqs_oe == {2{dq_oe}}; endproperty
    a_strb: assert property (p_strb) else $error("strobe");
    property p_cut; rdwr |=> !dq_oe; endproperty
    a_cut: assert property (p_cut) else $error("cut edge");
    property p_cs; fake_rd ##1 (!rdwr) [*4] |=> !$rose(dq_oe); endproperty
    a_cs: assert property (p_cs) else $error("deselected read");
    property p_hold; !dq_oe && !$past(dq_oe) |-> $stable(rdata_rise)
        && $stable(rdata_fall); endproperty
    a_hold: assert property (p_hold) else $error("idle data moved");
    property p_bl4; (rd && !bl8_reg) ##1 (!rdwr) [*6] |->
        dq_oe && $past(dq_oe) ##1 !dq_oe; endproperty
    a_bl4: assert property (p_bl4) else $error("bl4 length");
    property p_bl8; (rd && bl8_reg) ##1 (!rdwr) [*8] |->
        dq_oe && $past(dq_oe, 3) ##1 !dq_oe; endproperty
    a_bl8: assert property (p_bl8) else $error("bl8 length");
endmodule // ddrc_core_asserts
bind ddrc_core ddrc_core_asserts #(.ROW_W(ROW_W), .COL_W(COL_W), .CL(CL))
    u_chk (.ck, .srst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .dq_oe, .dqs_oe, .rdata_rise, .rdata_fall);
`default_nettype wire

/* File: ddrc_ctl_model.sv */
/* Controller model: commands and write bursts on the link clock.
   Assumes the device samples on the edge after each drive. */
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctl_model
    import ddrc_pkg::*;
(
    input wire logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    output logic [15:0] wdata_rise,
    output logic [15:0] wdata_fall,
    output logic [1:0] dm_rise,
    output logic [1:0] dm_fall,
    output logic [1:0] dqs_rise_in,
    output logic [1:0] dqs_fall_in
);
    // Idle bus at time zero
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = {2'b11, CMD_NOP};
        {ba, addr, dm_rise, dm_fall, dqs_rise_in, dqs_fall_in} = '0;
        {wdata_rise, wdata_fall} = 32'h0;
    end
    // One command, k is {cke, cs_n}
    task automatic cmd(input logic [1:0] k, input logic [2:0] op,
        input logic [1:0] b, input logic [12:0] a);
        @(posedge ck);
        {cke, cs_n, ras_n, cas_n, we_n} <= {k, op};
        ba <= b;
        addr <= a;
    endtask
    // Write burst of n pairs, strobe only while data is driven
    task automatic wr(input logic [1:0] b, input logic [12:0] a,
        input int n, input logic [127:0] d, input logic [15:0] m);
        cmd(2'b10, CMD_WRITE, b, a);
        repeat (READ_LAT_CYC - 1) cmd(2'b10, CMD_NOP, 2'h0, 13'h0);
        for (int p = 0; p < n; p++) begin
            cmd(2'b10, CMD_NOP, 2'h0, 13'h0);
            wdata_rise <= d[32*p +: 16];
            wdata_fall <= d[32*p+16 +: 16];
            dm_rise <= m[4*p +: 2];
            dm_fall <= m[4*p+2 +: 2];
            {dqs_rise_in, dqs_fall_in} <= 4'hF;
        end
        cmd(2'b10, CMD_NOP, 2'h0, 13'h0);
        {wdata_rise, wdata_fall} <= ~{wdata_rise, wdata_fall};
        {dm_rise, dm_fall, dqs_rise_in, dqs_fall_in} <= 8'hF0;
    endtask
endmodule // ddrc_ctl_model
`default_nettype wire

/* File: ddrc_pkg.sv */
/*
 * Constants shared by the DDR2 access core: command codes, mode fields,
 * reset values and latency figures.
 * Assumes a controller that drives commands on the link clock.
 */
`default_nettype none

package ddrc_pkg;

    // ------------------------------------------------------------------
    // Command codes as {ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ------------------------------------------------------------------
    // Mode register fields and address bit positions
    // ------------------------------------------------------------------
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam logic [2:0] MODE_BL4_CODE = 3'h2;
    localparam logic [2:0] MODE_BL8_CODE = 3'h3;
    localparam logic [1:0] MODE_REG_SEL = 2'h0;
    localparam int AUTO_PRE_BIT = 10;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic MODE_BL8_RST = 1'b0;
    localparam logic MODE_INTER_RST = 1'b0;
    localparam logic [3:0] BANKS_OPEN_RST = 4'h0;
    localparam int READ_LAT_CYC = 4;
    localparam int NUM_BANKS = 4;
    localparam int BYTES = 2;
    localparam int SYNC_STAGES = 2;

    // Power states of the die
    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_PDOWN,
        PS_SREF
    } ddrc_pstate_t;

endpackage

`default_nettype wire

/* File: test_ddr2_sdram_burst_access_core.sv */
/* Testbench: bursts, masks, banks and power states of ddrc_core.
   Assumes ddrc_ctl_model on the link side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_ddr2_sdram_burst_access_core
    import ddrc_pkg::*;
;
    logic clk = 1'b0, ck = 1'b0, srst = 1'b1, ce = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, dq_oe;
    logic stat_self_refresh, stat_power_down, stat_burst_busy;
    logic [1:0] ba, dm_rise, dm_fall, dqs_rise_in, dqs_fall_in, dqs_oe;
    logic [12:0] addr;
    logic [15:0] wdata_rise, wdata_fall, rdata_rise, rdata_fall;
    logic [3:0] stat_banks_open;
    logic [127:0] e8;
    int num_errors = 0, comparisons = 0;
    // Clocks of both domains
    always #5 clk = ~clk;
    always #6 ck = ~ck;
    ddrc_core #(.ROW_W(4), .COL_W(5)) u_dut (.clk, .srst, .ce, .ck, .cke,
        .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .wdata_rise, .wdata_fall,
        .dm_rise, .dm_fall, .dqs_rise_in, .dqs_fall_in, .rdata_rise,
        .rdata_fall, .dq_oe, .dqs_oe, .stat_banks_open, .stat_self_refresh,
        .stat_power_down, .stat_burst_busy);
    ddrc_ctl_model u_ctl (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .wdata_rise, .wdata_fall, .dm_rise, .dm_fall, .dqs_rise_in,
        .dqs_fall_in);
    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task c(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
        u_ctl.cmd(2'b10, op, b, a);
    endtask
    // Read burst of n pairs, each pair checked as it stands
    task rd(input logic [1:0] b, input logic [12:0] a, input int n,
        input logic [127:0] e);
        c(CMD_READ, b, a);
        repeat (READ_LAT_CYC) c(CMD_NOP, 2'h0, 13'h0);
        for (int p = 0; p < n; p++) begin
            c(CMD_NOP, 2'h0, 13'h0);
            #1 chk({rdata_fall, rdata_rise}, e[32*p +: 32]);
        end
    endtask
    // Status poll under a bounded count
    task st(input logic [5:0] e);
        repeat (40) begin
            @(posedge clk);
            if ({stat_self_refresh, stat_power_down, stat_banks_open} === e)
                break;
        end
        #1 chk(32'({stat_self_refresh, stat_power_down, stat_banks_open}),
            32'(e));
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_seq;
        c(CMD_LOAD_MODE, 2'h0, 13'h2);
        c(CMD_ACTIVE, 2'h1, 13'h3);
        u_ctl.wr(2'h1, 13'h4, 2, 128'h4444_3333_2222_1111, 16'h0);
        u_ctl.wr(2'h1, 13'h4, 2, 128'hDDDD_DDDD_DDDD_DDDD, 16'hFFFB);
        rd(2'h1, 13'h6, 2, 128'h22DD_1111_4444_3333);
        $display("t_seq done");
    endtask
    task t_bl8;
        for (int i = 0; i < 8; i++) e8[16*i +: 16] = 16'h0A00 + 16'(5 ^ i);
        c(CMD_LOAD_MODE, 2'h0, 13'hB);
        u_ctl.wr(2'h1, 13'h8, 4, 128'h0A07_0A06_0A05_0A04_0A03_0A02_0A01_0A00,
            16'h0);
        c(CMD_READ, 2'h1, 13'h8);
        // Second read lands after two pairs of the first have left
        repeat (5) c(CMD_NOP, 2'h0, 13'h0);
        rd(2'h1, 13'hD, 4, e8);
        $display("t_bl8 done");
    endtask
    task t_banks;
        c(CMD_ACTIVE, 2'h0, 13'h1);
        c(CMD_ACTIVE, 2'h2, 13'h2);
        st(6'h07);
        // Auto precharge write on bank 2; busy seen while it runs
        fork
            u_ctl.wr(2'h2, 13'h400, 4, 128'h0, 16'h0);
            begin
                repeat (40) begin
                    @(posedge clk);
                    if (stat_burst_busy === 1'b1)
                        break;
                end
                #1 chk(32'(stat_burst_busy), 32'h1);
            end
        join
        st(6'h03);
        c(CMD_PRECHARGE, 2'h0, 13'h0);
        st(6'h02);
        c(CMD_PRECHARGE, 2'h3, 13'h400);
        st(6'h00);
        $display("t_banks done");
    endtask
    task t_pwr;
        u_ctl.cmd(2'b11, CMD_ACTIVE, 2'h3, 13'h0);
        u_ctl.cmd(2'b11, CMD_READ, 2'h0, 13'h0);
        repeat (6) c(CMD_NOP, 2'h0, 13'h0);
        st(6'h00);
        u_ctl.cmd(2'b01, CMD_NOP, 2'h0, 13'h0);
        st(6'h10);
        c(CMD_NOP, 2'h0, 13'h0);
        st(6'h00);
        u_ctl.cmd(2'b00, CMD_REFRESH, 2'h0, 13'h0);
        u_ctl.cmd(2'b01, CMD_NOP, 2'h0, 13'h0);
        st(6'h20);
        c(CMD_NOP, 2'h0, 13'h0);
        st(6'h00);
        c(CMD_ACTIVE, 2'h1, 13'h3);
        repeat (2) c(CMD_NOP, 2'h0, 13'h0);
        rd(2'h1, 13'hD, 4, e8);
        $display("t_pwr done");
    endtask
    // Clock enable low: an activation is not taken
    task t_ce;
        @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge ck);
        c(CMD_ACTIVE, 2'h0, 13'h1);
        c(CMD_NOP, 2'h0, 13'h0);
        @(posedge clk);
        ce <= 1'b1;
        repeat (6) @(posedge ck);
        st(6'h02);
        $display("t_ce done");
    endtask
    task finish_test;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence after reset
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge ck);
        t_seq;
        t_bl8;
        t_banks;
        t_pwr;
        t_ce;
        finish_test;
    end
    // Watchdog
    initial begin
        #50000;
        num_errors++;
        finish_test;
    end
endmodule // test_ddr2_sdram_burst_access_core
`default_nettype wire
